//--- rtl/rtd_params.svh
// register offsets, field positions, reset values and timing for the ring trip detector
`ifndef RTD_PARAMS_SVH
`define RTD_PARAMS_SVH
// register indexes; byte address is four times the index
`define RTD_IDX_PENDING 8'h26
`define RTD_IDX_ENABLE 8'h27
`define RTD_IDX_AUTO 8'h43
`define RTD_IDX_LINEFEED 8'h44
`define RTD_IDX_STATUS 8'h46
`define RTD_IDX_AC_DEB 8'h48
`define RTD_IDX_AC_COEF_LO 8'h51
`define RTD_IDX_AC_COEF_HI 8'h52
`define RTD_IDX_AC_THR 8'h55
`define RTD_IDX_DC_COEF_LO 8'h65
`define RTD_IDX_DC_COEF_HI 8'h66
`define RTD_IDX_DC_THR 8'h67
`define RTD_IDX_DC_DEB 8'h68
`define RTD_IDX_LOOP_CUR 8'h90
// field positions
`define RTD_BIT_PEND_TRIP 0
`define RTD_BIT_EN_TRIP 0
`define RTD_BIT_AUTO_RING 1
`define RTD_BIT_STAT_TRIP 1
`define RTD_BIT_STAT_AC_RAW 3
`define RTD_BIT_STAT_DC_RAW 4
`define RTD_BIT_LF_POL 3
// linefeed state codes
`define RTD_LF_OPEN 4'h0
`define RTD_LF_ACTIVE 4'h1
`define RTD_LF_RINGING 4'h4
// reset values: thresholds at maximum keep both paths quiet for magnitudes below 65 codes
`define RTD_RST_THR 8'h3F
`define RTD_RST_DEB 8'h00
`define RTD_RST_COEF 12'h000
`define RTD_RST_BYTE 8'h00
// threshold step 1.27 mA and sample step 1.25 mA, both in 10 uA units
`define RTD_THR_STEP 20'd127
`define RTD_CUR_STEP 20'd125
// supervision sample period in us (800 Hz) and clock period in ns
`define RTD_SAMPLE_PERIOD_US 1250
`define RTD_CLK_PERIOD_NS 10
`define RTD_SAMPLE_CYCLES (`RTD_SAMPLE_PERIOD_US * 1000 / `RTD_CLK_PERIOD_NS)
`endif

//--- rtl/rtd_pkg.sv
// shared types of the ring trip detector
package rtd_pkg;
  typedef logic [7:0] rtd_byte_t;
  typedef logic [11:0] rtd_coef_t;
  typedef logic signed [12:0] rtd_val_t;
endpackage

//--- rtl/rtd_ring_trip.sv
// ring trip detector: dual-path loop current evaluation with an apb register file
`timescale 1ns/1ns
`include "rtd_params.svh"
module rtd_ring_trip #(
  parameter int SAMPLE_CYCLES = `RTD_SAMPLE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] loop_current_sample,
  output logic [3:0] shadow_linefeed_state,
  output logic ring_trip_detected,
  output logic ring_trip_irq
);
  import rtd_pkg::*;

  // register file
  rtd_byte_t pending_reg;
  rtd_byte_t enable_reg;
  rtd_byte_t auto_reg;
  logic [3:0] lf_req_reg;
  logic [3:0] shadow_reg;
  logic pol_reg;
  rtd_byte_t ac_deb_reg;
  rtd_byte_t dc_deb_reg;
  rtd_byte_t ac_thr_reg;
  rtd_byte_t dc_thr_reg;
  rtd_coef_t ac_coef_reg;
  rtd_coef_t dc_coef_reg;
  logic [11:0] cur_reg;
  // datapath state
  logic [16:0] div_reg;
  logic tick;
  rtd_val_t ac_filt_reg;
  rtd_val_t dc_filt_reg;
  logic [7:0] cnt_reg [2];
  logic [1:0] valid_reg;
  logic trip_d_reg;
  logic ringing;
  logic ac_raw;
  logic dc_raw;
  logic trip_rise;
  logic [1:0] raw;
  logic [7:0] deb [2];
  logic wr_en;
  logic rd_setup;
  logic [9:0] idx;
  logic mapped;
  logic [31:0] rd_mux;

  // magnitude of a signed value
  function automatic rtd_val_t rect(input rtd_val_t v);
    rect = v[12] ? -v : v;
  endfunction

  // one step of y += (x - y) * (1 - c/4096)
  function automatic rtd_val_t lpf_step(input rtd_val_t y, input rtd_val_t x,
                                        input rtd_coef_t c);
    logic signed [13:0] diff;
    logic signed [13:0] gain;
    logic signed [27:0] prod;
    logic signed [14:0] sum;
    diff = 14'(x) - 14'(y);
    gain = 14'sh1000 - $signed({2'b00, c});
    prod = 28'(diff) * 28'(gain);
    sum = 15'(y) + 15'(prod >>> 12);
    lpf_step = sum[12:0];
  endfunction

  // magnitude in 1.25 mA steps against threshold code in 1.27 mA steps
  function automatic logic over_thr(input rtd_val_t mag, input rtd_byte_t thr);
    logic [19:0] cur_ua;
    logic [19:0] thr_ua;
    cur_ua = 20'(mag[11:0]) * `RTD_CUR_STEP;
    thr_ua = 20'(thr[5:0]) * `RTD_THR_STEP;
    over_thr = cur_ua > thr_ua;
  endfunction

  // apb decode; byte address is four times the register index
  assign idx = paddr[11:2];
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1; // zero wait states
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (idx)
      10'(`RTD_IDX_PENDING): rd_mux[7:0] = pending_reg;
      10'(`RTD_IDX_ENABLE): rd_mux[7:0] = enable_reg;
      10'(`RTD_IDX_AUTO): rd_mux[7:0] = auto_reg;
      10'(`RTD_IDX_LINEFEED): rd_mux[7:0] = {shadow_reg, lf_req_reg};
      10'(`RTD_IDX_STATUS): begin
        rd_mux[`RTD_BIT_STAT_TRIP] = ring_trip_detected;
        rd_mux[`RTD_BIT_STAT_AC_RAW] = ac_raw;
        rd_mux[`RTD_BIT_STAT_DC_RAW] = dc_raw;
      end
      10'(`RTD_IDX_AC_DEB): rd_mux[7:0] = ac_deb_reg;
      10'(`RTD_IDX_AC_COEF_LO): rd_mux[7:0] = ac_coef_reg[7:0];
      10'(`RTD_IDX_AC_COEF_HI): rd_mux[3:0] = ac_coef_reg[11:8];
      10'(`RTD_IDX_AC_THR): rd_mux[5:0] = ac_thr_reg[5:0];
      10'(`RTD_IDX_DC_COEF_LO): rd_mux[7:0] = dc_coef_reg[7:0];
      10'(`RTD_IDX_DC_COEF_HI): rd_mux[3:0] = dc_coef_reg[11:8];
      10'(`RTD_IDX_DC_THR): rd_mux[5:0] = dc_thr_reg[5:0];
      10'(`RTD_IDX_DC_DEB): rd_mux[7:0] = dc_deb_reg;
      10'(`RTD_IDX_LOOP_CUR): rd_mux[11:0] = cur_reg;
      default: mapped = 1'b0;
    endcase
  end

  // read data is captured in the setup cycle so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // plain software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= `RTD_RST_BYTE;
      auto_reg <= `RTD_RST_BYTE;
      ac_deb_reg <= `RTD_RST_DEB;
      dc_deb_reg <= `RTD_RST_DEB;
      ac_thr_reg <= `RTD_RST_THR;
      dc_thr_reg <= `RTD_RST_THR;
      ac_coef_reg <= `RTD_RST_COEF;
      dc_coef_reg <= `RTD_RST_COEF;
    end else if (wr_en) begin
      unique case (idx)
        10'(`RTD_IDX_ENABLE): enable_reg <= pwdata[7:0];
        10'(`RTD_IDX_AUTO): auto_reg <= pwdata[7:0];
        10'(`RTD_IDX_AC_DEB): ac_deb_reg <= pwdata[7:0];
        10'(`RTD_IDX_DC_DEB): dc_deb_reg <= pwdata[7:0];
        10'(`RTD_IDX_AC_THR): ac_thr_reg <= {2'b00, pwdata[5:0]};
        10'(`RTD_IDX_DC_THR): dc_thr_reg <= {2'b00, pwdata[5:0]};
        10'(`RTD_IDX_AC_COEF_LO): ac_coef_reg[7:0] <= pwdata[7:0];
        10'(`RTD_IDX_AC_COEF_HI): ac_coef_reg[11:8] <= pwdata[3:0];
        10'(`RTD_IDX_DC_COEF_LO): dc_coef_reg[7:0] <= pwdata[7:0];
        10'(`RTD_IDX_DC_COEF_HI): dc_coef_reg[11:8] <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // linefeed request: a trip in auto mode beats a software write of the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lf_req_reg <= `RTD_LF_OPEN;
      pol_reg <= 1'b0;
    end else if (trip_rise && auto_reg[`RTD_BIT_AUTO_RING]) begin
      lf_req_reg <= `RTD_LF_ACTIVE | {pol_reg, 3'b000};
    end else if (wr_en && idx == 10'(`RTD_IDX_LINEFEED)) begin
      lf_req_reg <= pwdata[3:0];
      if (pwdata[3:0] != `RTD_LF_RINGING) begin
        pol_reg <= pwdata[`RTD_BIT_LF_POL]; // polarity to return to after ringing
      end
    end
  end

  // shadow state trails the request by one cycle, as the line driver would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_reg <= `RTD_LF_OPEN;
    end else begin
      shadow_reg <= lf_req_reg;
    end
  end
  assign shadow_linefeed_state = shadow_reg;
  assign ringing = shadow_reg == `RTD_LF_RINGING;

  // 800 Hz supervision tick from the 100 MHz clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 17'h0_0000;
    end else if (div_reg == 17'(SAMPLE_CYCLES - 1)) begin
      div_reg <= 17'h0_0000;
    end else begin
      div_reg <= div_reg + 17'h0_0001;
    end
  end
  assign tick = div_reg == 17'(SAMPLE_CYCLES - 1);

  // loop current capture, visible to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_reg <= 12'h000;
    end else if (tick) begin
      cur_reg <= loop_current_sample;
    end
  end

  // filters are held at zero outside ringing so each ring starts clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ac_filt_reg <= 13'sh0000;
      dc_filt_reg <= 13'sh0000;
    end else if (!ringing) begin
      ac_filt_reg <= 13'sh0000;
      dc_filt_reg <= 13'sh0000;
    end else if (tick) begin
      ac_filt_reg <= lpf_step(ac_filt_reg, rect(13'(signed'(cur_reg))), ac_coef_reg);
      dc_filt_reg <= lpf_step(dc_filt_reg, 13'(signed'(cur_reg)), dc_coef_reg);
    end
  end

  // raw comparisons; the dc value is rectified after filtering
  assign ac_raw = ringing && over_thr(ac_filt_reg, ac_thr_reg);
  assign dc_raw = ringing && over_thr(rect(dc_filt_reg), dc_thr_reg);
  assign raw = {dc_raw, ac_raw};
  assign deb[0] = ac_deb_reg;
  assign deb[1] = dc_deb_reg;

  // debounce: count 1.25 ms ticks while over threshold, restart on any drop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg[0] <= 8'h00;
      cnt_reg[1] <= 8'h00;
      valid_reg <= 2'b00;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (!raw[p]) begin
          cnt_reg[p] <= 8'h00;
          valid_reg[p] <= 1'b0;
        end else if (tick) begin
          if (cnt_reg[p] >= deb[p]) begin
            valid_reg[p] <= 1'b1;
          end else begin
            cnt_reg[p] <= cnt_reg[p] + 8'h01;
          end
        end
      end
    end
  end

  // combined status and its rising edge
  assign ring_trip_detected = |valid_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_d_reg <= 1'b0;
    end else begin
      trip_d_reg <= ring_trip_detected;
    end
  end
  assign trip_rise = ring_trip_detected && !trip_d_reg;

  // pending flag: write one to clear, a new trip wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= `RTD_RST_BYTE;
    end else if (trip_rise) begin
      pending_reg[`RTD_BIT_PEND_TRIP] <= 1'b1;
    end else if (wr_en && idx == 10'(`RTD_IDX_PENDING) && pwdata[`RTD_BIT_PEND_TRIP]) begin
      pending_reg[`RTD_BIT_PEND_TRIP] <= 1'b0;
    end
  end
  assign ring_trip_irq = pending_reg[`RTD_BIT_PEND_TRIP] && enable_reg[`RTD_BIT_EN_TRIP];

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  idle_no_trip_a: assert property (!ringing |=> !ring_trip_detected)
    else $error("trip seen outside ringing");
  idle_filt_zero_a: assert property (!ringing |=> ac_filt_reg == 0 && dc_filt_reg == 0)
    else $error("filter ran outside ringing");
  cur_capture_a: assert property (tick |=> cur_reg == $past(loop_current_sample))
    else $error("loop current not captured");
  ac_deb_a: assert property ($rose(valid_reg[0]) |-> $past(ac_raw) && $past(tick)
                            && $past(cnt_reg[0]) >= $past(ac_deb_reg))
    else $error("ac trip before debounce");
  dc_deb_a: assert property ($rose(valid_reg[1]) |-> $past(dc_raw) && $past(tick)
                            && $past(cnt_reg[1]) >= $past(dc_deb_reg))
    else $error("dc trip before debounce");
  ac_status_a: assert property (rd_setup && idx == 10'(`RTD_IDX_STATUS)
                                |=> prdata[3] == $past(ac_raw))
    else $error("ac raw bit wrong");
  dc_status_a: assert property (rd_setup && idx == 10'(`RTD_IDX_STATUS)
                                |=> prdata[4] == $past(dc_raw))
    else $error("dc raw bit wrong");
  // raw comparators stay quiet outside ringing
  raw_quiet_a: assert property (!ringing |-> !ac_raw && !dc_raw)
    else $error("raw trip outside ringing");
  // every ring starts from clean filters and counters
  ring_entry_a: assert property ($rose(ringing) |-> ac_filt_reg == 0 && dc_filt_reg == 0
                                 && cnt_reg[0] == 0 && cnt_reg[1] == 0)
    else $error("ring started with stale state");
  // write one clears the pending flag unless a trip lands in the same cycle
  pend_clr_a: assert property (wr_en && idx == 10'(`RTD_IDX_PENDING) && pwdata[0]
                               && !trip_rise |=> !pending_reg[0])
    else $error("pending not cleared");
  pend_set_a: assert property (trip_rise |=> pending_reg[0] [*2])
    else $error("pending not held after trip");
  irq_gate_a: assert property (ring_trip_irq |-> enable_reg[0] && pending_reg[0])
    else $error("interrupt not gated");
  auto_active_a: assert property (trip_rise && auto_reg[1] |=> lf_req_reg[2:0] == 3'h1
                                  && lf_req_reg[3] == $past(pol_reg) ##1 !ringing)
    else $error("no automatic move to active");
  // without the auto bit a trip leaves the linefeed request alone
  auto_off_hold_a: assert property (trip_rise && !auto_reg[1]
                                    && !(wr_en && idx == 10'(`RTD_IDX_LINEFEED))
                                    |=> lf_req_reg == $past(lf_req_reg))
    else $error("linefeed moved without auto bit");
  drop_restart_a: assert property (!raw[0] |=> cnt_reg[0] == 0 && !valid_reg[0])
    else $error("debounce not restarted");
  dc_restart_a: assert property (!raw[1] |=> cnt_reg[1] == 0 && !valid_reg[1])
    else $error("dc debounce not restarted");

  ac_trip_c: cover property (ringing ##1 $rose(valid_reg[0]));
  dc_trip_c: cover property (ringing ##1 $rose(valid_reg[1]));
  auto_move_c: cover property (trip_rise && auto_reg[1] ##2 shadow_reg[2:0] == 3'h1);
  clear_race_c: cover property (trip_rise && wr_en && idx == 10'(`RTD_IDX_PENDING));
  pend_clear_c: cover property (pending_reg[0] ##1 !pending_reg[0]);
endmodule

//--- tb/rtd_loop_model.sv
// loop current measurement model: steady or sign-alternating samples
`timescale 1ns/1ns
module rtd_loop_model #(
  parameter int SAMPLE_CYCLES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] level,
  input wire logic alt,
  output logic [11:0] sample
);
  int cnt;
  logic neg;
  // sign flips once per tick period, so a ringing current averages to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      neg <= 1'b0;
    end else if (cnt == SAMPLE_CYCLES - 1) begin
      cnt <= 0;
      neg <= alt & ~neg;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // two's complement, as the measurement delivers it
  assign sample = neg ? 12'(-level) : level;
endmodule

//--- tb/rtd_ring_trip_test.sv
// self-checking bench for the ring trip detector over apb
`timescale 1ns/1ns
`include "rtd_params.svh"
module rtd_ring_trip_test;
  import rtd_pkg::*;
  localparam int SC = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, ring_trip_detected, ring_trip_irq, err;
  logic [3:0] shadow_linefeed_state;
  logic [11:0] loop_current_sample;
  logic [11:0] lvl = 12'h000;
  logic alt = 1'b0;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;

  rtd_ring_trip #(.SAMPLE_CYCLES(SC)) i_rtd_ring_trip (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .loop_current_sample(loop_current_sample), .shadow_linefeed_state(shadow_linefeed_state),
    .ring_trip_detected(ring_trip_detected), .ring_trip_irq(ring_trip_irq));
  rtd_loop_model #(.SAMPLE_CYCLES(SC)) i_rtd_loop_model (.pclk(pclk), .presetn(presetn),
    .level(lvl), .alt(alt), .sample(loop_current_sample));

  initial forever #5 pclk = ~pclk;

  // hang guard: the whole run needs well under this many cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // pready seen high ends this wait; the bench timeout catches a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(nm, exp, rd);
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, read-only and unmapped places
    rdc("ac_thr", `RTD_IDX_AC_THR, 32'h3F);
    rdc("dc_thr", `RTD_IDX_DC_THR, 32'h3F);
    rdc("ac_deb", `RTD_IDX_AC_DEB, 32'h0);
    rdc("pending", `RTD_IDX_PENDING, 32'h0);
    apb(1'b0, 8'h30, 8'h00);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    apb(1'b1, `RTD_IDX_STATUS, 8'hFF);
    rdc("status_ro", `RTD_IDX_STATUS, 32'h0);
    $display("test reset done");
    // dc level above threshold but not ringing: no detection
    lvl <= 12'h028;
    apb(1'b1, `RTD_IDX_DC_THR, 8'h1E);
    apb(1'b1, `RTD_IDX_DC_DEB, 8'h02);
    repeat (6 * SC) @(posedge pclk);
    rdc("status_idle", `RTD_IDX_STATUS, 32'h0);
    rdc("loop_cur", `RTD_IDX_LOOP_CUR, 32'h028);
    $display("test idle done");
    // dc path trip while ringing, auto move keeps reverse polarity
    apb(1'b1, `RTD_IDX_ENABLE, 8'h01);
    apb(1'b1, `RTD_IDX_AUTO, 8'h02);
    apb(1'b1, `RTD_IDX_LINEFEED, 8'h08);
    apb(1'b1, `RTD_IDX_LINEFEED, 8'h04);
    repeat (SC + 1) @(posedge pclk);
    rdc("dc_raw", `RTD_IDX_STATUS, 32'h10);
    n = 0;
    while (ring_trip_detected !== 1'b1 && n < 6 * SC) begin
      @(posedge pclk);
      n++;
    end
    chk("detected", 32'h1, {31'h0, ring_trip_detected});
    repeat (3) @(posedge pclk);
    chk("irq", 32'h1, {31'h0, ring_trip_irq});
    chk("shadow", 32'h9, {28'h0, shadow_linefeed_state});
    rdc("pend_set", `RTD_IDX_PENDING, 32'h1);
    apb(1'b1, `RTD_IDX_ENABLE, 8'h00);
    @(posedge pclk); // the write lands at the access edge, seen one edge later
    chk("irq_masked", 32'h0, {31'h0, ring_trip_irq});
    apb(1'b1, `RTD_IDX_PENDING, 8'h01);
    rdc("pend_clr", `RTD_IDX_PENDING, 32'h0);
    rdc("status_active", `RTD_IDX_STATUS, 32'h0);
    $display("test dc trip done");
    // ac path: slow dc filter, ac threshold around the 40-code current
    apb(1'b1, `RTD_IDX_DC_COEF_LO, 8'hFF);
    apb(1'b1, `RTD_IDX_DC_COEF_HI, 8'h0F);
    rdc("coef_hi", `RTD_IDX_DC_COEF_HI, 32'h0F);
    apb(1'b1, `RTD_IDX_DC_THR, 8'h3F);
    apb(1'b1, `RTD_IDX_AC_THR, 8'h28);
    apb(1'b1, `RTD_IDX_AUTO, 8'h00);
    alt <= 1'b1;
    apb(1'b1, `RTD_IDX_LINEFEED, 8'h00);
    apb(1'b1, `RTD_IDX_LINEFEED, 8'h04);
    repeat (3 * SC) @(posedge pclk);
    rdc("ac_at_thr", `RTD_IDX_STATUS, 32'h0);
    apb(1'b1, `RTD_IDX_AC_THR, 8'h27);
    repeat (3 * SC) @(posedge pclk);
    rdc("ac_trip", `RTD_IDX_STATUS, 32'h0A);
    chk("no_auto", 32'h4, {28'h0, shadow_linefeed_state});
    $display("test ac trip done");
    end_sim();
  end
endmodule
